/* bench/pad_config_and_gpio_port_tb.sv */
`timescale 1ns/10ps
module pad_config_and_gpio_port_tb;
  typedef struct
  {
    logic [7:0] a;
    logic [12:0] w;
    logic [7:0] r;
    logic [11:0] e;
  } pcgp_row_t;
  localparam logic [7:0] CF = pcgp_pkg::A_CFG0;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [11:0] i_per_out = 12'h000;
  logic [11:0] i_per_oe = 12'h000;
  logic i_dpd = 1'b0;
  logic [11:0] ext_en = 12'hfff;
  logic [11:0] ext_val = 12'h000;
  logic [31:0] o_rdata;
  logic [11:0] pin;
  logic [11:0] per_in;
  logic [11:0] o_pad_out;
  logic [11:0] o_pad_oe;
  logic [11:0] o_pull_up;
  logic [11:0] o_pull_dn;
  logic [11:0] o_bus_filt;
  logic [11:0] o_sink_en;
  logic [35:0] o_sink_lvl;
  logic o_port_irq;
  logic [10:0] o_wake;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] d;
  pcgp_row_t rows [10];

  pcgp_top #(.P_NWAKE(pcgp_pkg::NWAKE)) i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pad_in(pin), .i_per_out(i_per_out), .i_per_oe(i_per_oe),
    .i_dpd(i_dpd), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
    .o_pull_up(o_pull_up), .o_pull_dn(o_pull_dn),
    .o_bus_filt(o_bus_filt), .o_sink_en(o_sink_en),
    .o_sink_lvl(o_sink_lvl), .o_per_in(per_in), .o_port_irq(o_port_irq),
    .o_wake(o_wake)
  );

  pcgp_pad_env i_pads (
    .i_clk(i_clk), .i_out(o_pad_out), .i_oe(o_pad_oe),
    .i_pu(o_pull_up), .i_pd(o_pull_dn), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pin(pin)
  );

  initial
  begin
    forever #20 i_clk = ~i_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [12:0] v);
    i_addr <= a;
    i_wdata <= {19'h0, v};
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (o_port_irq !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    if (o_port_irq !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
  endtask

  initial
  begin
    rows = '{
      '{pcgp_pkg::A_DIR, 13'h0fff, pcgp_pkg::A_DIR, 12'hfff},
      '{pcgp_pkg::A_DATA, 13'h03a5, 8'hff, 12'h385},
      '{pcgp_pkg::A_MASK, 13'h000f, pcgp_pkg::A_MASK, 12'h00f},
      '{pcgp_pkg::A_MDATA, 13'h00fa, 8'hff, 12'h38a},
      '{pcgp_pkg::A_SET, 13'h0040, 8'hff, 12'h3ca},
      '{pcgp_pkg::A_CLR, 13'h0302, 8'hff, 12'h0c8},
      '{pcgp_pkg::A_DCLR, 13'h0ff0, pcgp_pkg::A_DIR, 12'h00f},
      '{pcgp_pkg::A_DSET, 13'h00f0, pcgp_pkg::A_DIR, 12'h0ff},
      '{pcgp_pkg::A_DTGL, 13'h03c3, pcgp_pkg::A_DIR, 12'h33c},
      '{pcgp_pkg::A_IST, 13'h0fff, 8'h30, 12'h000}};
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    cyc(3);
    chk("rst_oe", 12'h000, o_pad_oe);
    chk("rst_pull", 24'hc00000, {o_pull_up, o_pull_dn});
    chk("rst_filt", 12'h030, o_bus_filt);
    rd(CF + 8'h10);
    chk("rst_cfg4", 13'h0021, d[12:0]);
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].w);
      cyc(1);
      if (rows[k].r == 8'hff)
        chk("pad_out", rows[k].e,
            o_pad_out & 12'h3cf);
      else
      begin
        rd(rows[k].r);
        chk("rdata", rows[k].e, d[11:0]);
      end
    end
    wr(pcgp_pkg::A_DIR, 13'h0000);
    cyc(6);
    wr(pcgp_pkg::A_ICLR, 13'h0fff);
    wr(pcgp_pkg::A_IEN, 13'h0004);
    cyc(2);
    chk("irq_idle", 1'b0, o_port_irq);
    ext_val[2] <= 1'b1;
    wait_irq();
    rd(pcgp_pkg::A_IST);
    chk("ist", 12'h004, d[11:0]);
    chk("wake", 11'h004, o_wake);
    chk("per_in", 12'h004, per_in);
    wr(pcgp_pkg::A_IEN, 13'h0000);
    cyc(2);
    chk("irq_mask", 1'b0, o_port_irq);
    wr(pcgp_pkg::A_IEN, 13'h0004);
    cyc(2);
    chk("irq_en", 1'b1, o_port_irq);
    wr(pcgp_pkg::A_ICLR, 13'h0004);
    cyc(2);
    chk("irq_clr", 12'h000, {o_port_irq, o_wake});
    wr(CF + 8'h04, 13'h0018);
    ext_val[1] <= 1'b1;
    cyc(6);
    ext_en[1] <= 1'b0;
    cyc(8);
    chk("rep_hold", 3'b110, {pin[1], o_pull_up[1], o_pull_dn[1]});
    i_dpd <= 1'b1;
    cyc(3);
    chk("rep_dpd", 2'b00, {o_pull_up[1], o_pull_dn[1]});
    i_dpd <= 1'b0;
    ext_en[1] <= 1'b1;
    wr(CF + 8'h04, 13'h0008);
    cyc(2);
    chk("mode_pd", 2'b01, {o_pull_up[1], o_pull_dn[1]});
    wr(pcgp_pkg::A_DIR, 13'h0001);
    wr(CF, 13'h0001);
    cyc(2);
    chk("per_off", 1'b0, o_pad_oe[0]);
    i_per_oe <= 12'h001;
    i_per_out <= 12'h001;
    cyc(2);
    chk("per_drv", 2'b11, {o_pad_oe[0], o_pad_out[0]});
    i_per_oe <= 12'h000;
    wr(CF, 13'h0000);
    cyc(2);
    chk("port_dir", 1'b1, o_pad_oe[0]);
    wr(CF + 8'h0c, 13'h1540);
    wr(CF + 8'h08, 13'h1540);
    wr(pcgp_pkg::A_SET, 13'h0008);
    cyc(2);
    chk("sink_hi", 4'hd, {o_sink_en[3], o_sink_lvl[11:9]});
    chk("sink_no", 1'b0, o_sink_en[2]);
    wr(pcgp_pkg::A_CLR, 13'h0008);
    cyc(2);
    chk("sink_lo", 3'h2, o_sink_lvl[11:9]);
    wr(CF + 8'h10, 13'h0001);
    cyc(2);
    chk("filt_off", 1'b0, o_bus_filt[4]);
    i_srst <= 1'b1;
    cyc(2);
    i_srst <= 1'b0;
    cyc(3);
    rd(pcgp_pkg::A_DIR);
    chk("rst2_dir", 12'h000, d[11:0]);
    complete_run();
  end
endmodule

/* bench/pcgp_pad_env.sv */
`timescale 1ns/10ps
module pcgp_pad_env (
  input wire logic i_clk,
  input wire logic [11:0] i_out,
  input wire logic [11:0] i_oe,
  input wire logic [11:0] i_pu,
  input wire logic [11:0] i_pd,
  input wire logic [11:0] i_ext_en,
  input wire logic [11:0] i_ext_val,
  output logic [11:0] o_pin
);
  // Pad level: device drive, then external drive, then pulls
  // A floating pad flips every cycle so it never looks stable
  logic [11:0] lvl_q = 12'h000;
  always_ff @(posedge i_clk)
  begin
    for (int i = 0; i < 12; i++)
    begin
      if (i_oe[i])
        lvl_q[i] <= i_out[i];
      else if (i_ext_en[i])
        lvl_q[i] <= i_ext_val[i];
      else if (i_pu[i])
        lvl_q[i] <= 1'b1;
      else if (i_pd[i])
        lvl_q[i] <= 1'b0;
      else
        lvl_q[i] <= ~lvl_q[i];
    end
  end
  assign o_pin = lvl_q;
endmodule

/* hdl/pcgp_pad.sv */
`timescale 1ns/10ps
module pcgp_pad #(
  parameter bit P_BUS = 1'b0,
  parameter bit P_HD = 1'b0
) (
  input wire logic [12:0] i_cfg,
  input wire logic i_port_out,
  input wire logic i_port_dir,
  input wire logic i_per_out,
  input wire logic i_per_oe,
  input wire logic i_pin,
  input wire logic i_dpd,
  output logic o_out,
  output logic o_oe,
  output logic o_pu,
  output logic o_pd,
  output logic o_filt,
  output logic o_sink,
  output logic [2:0] o_lvl
);
  logic port;
  pcgp_pkg::pcgp_mode_t mode;

  always_comb
  begin
    port = i_cfg[pcgp_pkg::CF_PSEL+:3] == pcgp_pkg::PSEL_PORT;
    mode = pcgp_pkg::pcgp_mode_t'(i_cfg[pcgp_pkg::CF_MODE+:2]);
    o_out = port ? i_port_out : i_per_out;
    o_oe = port ? i_port_dir : i_per_oe;
    o_filt = 1'b0;
    if (P_BUS && !port)
    begin
      o_out = 1'b0;
      o_oe = i_per_oe & ~i_per_out;
      o_filt = i_cfg[pcgp_pkg::CF_BUSF];
    end
    // Repeater follows the pin; released in deep power-down
    o_pu = mode == pcgp_pkg::MODE_PU ||
      (mode == pcgp_pkg::MODE_REP && i_pin && !i_dpd);
    o_pd = mode == pcgp_pkg::MODE_PD ||
      (mode == pcgp_pkg::MODE_REP && !i_pin && !i_dpd);
    o_sink = P_HD && i_cfg[pcgp_pkg::CF_SINK];
    o_lvl = 3'h0;
    if (o_sink)
    begin
      o_lvl = o_out ? i_cfg[pcgp_pkg::CF_SINK_HI+:3] :
        i_cfg[pcgp_pkg::CF_SINK_LO+:3];
    end
  end
endmodule

/* hdl/pcgp_sync.sv */
`timescale 1ns/10ps
module pcgp_sync #(
  parameter int P_W = 12
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [P_W-1:0] i_d,
  output logic [P_W-1:0] o_q
);
  typedef struct packed {
    logic [P_W-1:0] s1;
    logic [P_W-1:0] s2;
  } pcgp_sync_t;
  pcgp_sync_t q;
  pcgp_sync_t d;

  if (P_W < 1)
  begin : g_chk
    $error("pcgp_sync width must be at least one");
  end

  always_comb
  begin
    d.s1 = i_d;
    d.s2 = q.s1;
    if (i_srst)
    begin
      d = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    q <= d;
  end

  assign o_q = q.s2;
endmodule

/* hdl/pcgp_top.sv */
`timescale 1ns/10ps
module pcgp_top #(
  parameter int P_NWAKE = pcgp_pkg::NWAKE
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [11:0] i_pad_in,
  input wire logic [11:0] i_per_out,
  input wire logic [11:0] i_per_oe,
  input wire logic i_dpd,
  output logic [11:0] o_pad_out,
  output logic [11:0] o_pad_oe,
  output logic [11:0] o_pull_up,
  output logic [11:0] o_pull_dn,
  output logic [11:0] o_bus_filt,
  output logic [11:0] o_sink_en,
  output logic [35:0] o_sink_lvl,
  output logic [11:0] o_per_in,
  output logic o_port_irq,
  output logic [P_NWAKE-1:0] o_wake
);
  typedef struct packed {
    logic [11:0] out;
    logic [11:0] dir;
    logic [11:0] mask;
    logic [11:0] ist;
    logic [11:0] ien;
    logic [11:0] prev;
    logic arm;
    logic [11:0][12:0] cfg;
    logic [31:0] rdata;
    logic [11:0] pad_o;
    logic [11:0] pad_oe;
    logic [11:0] pu;
    logic [11:0] pd;
    logic [11:0] filt;
    logic [11:0] sink;
    logic [11:0][2:0] slvl;
    logic [11:0] per_in;
    logic [P_NWAKE-1:0] wake;
    logic irq;
  } pcgp_state_t;

  pcgp_state_t q;
  pcgp_state_t d;
  logic [11:0] pin;
  logic [11:0] ev;
  logic [11:0] clr;
  logic [4:0] sel;
  logic [11:0] w;
  logic [11:0] p_out;
  logic [11:0] p_oe;
  logic [11:0] p_pu;
  logic [11:0] p_pd;
  logic [11:0] p_filt;
  logic [11:0] p_sink;
  logic [11:0][2:0] p_lvl;

  if (P_NWAKE < 1 || P_NWAKE > pcgp_pkg::NPAD)
  begin : g_chk
    $error("pcgp_top wake line count out of range");
  end

  // Configuration register hit and pad index
  function automatic logic [4:0] cfg_sel(input logic [7:0] a);
    logic [7:0] off;
    off = a - pcgp_pkg::A_CFG0;
    cfg_sel = {a >= pcgp_pkg::A_CFG0 && off[1:0] == 2'b00 &&
      off[7:2] < 6'(pcgp_pkg::NPAD), off[5:2]};
  endfunction

  function automatic logic [12:0] cfg_rst(input int i);
    cfg_rst = pcgp_pkg::CFG_RST;
    if (pcgp_pkg::BUS_MASK[i])
    begin
      cfg_rst = pcgp_pkg::CFG_RST_BUS;
    end
    if (pcgp_pkg::DBG_MASK[i])
    begin
      cfg_rst = pcgp_pkg::CFG_RST_DBG;
    end
  endfunction

  pcgp_sync #(
    .P_W(pcgp_pkg::NPAD)
  ) u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_d(i_pad_in),
    .o_q(pin)
  );

  // Port bit i always belongs to pad i
  for (genvar i = 0; i < pcgp_pkg::NPAD; i++)
  begin : g_pad
    pcgp_pad #(
      .P_BUS(pcgp_pkg::BUS_MASK[i]),
      .P_HD(pcgp_pkg::HD_MASK[i])
    ) u_pad (
      .i_cfg(q.cfg[i]),
      .i_port_out(q.out[i]),
      .i_port_dir(q.dir[i]),
      .i_per_out(i_per_out[i]),
      .i_per_oe(i_per_oe[i]),
      .i_pin(pin[i]),
      .i_dpd(i_dpd),
      .o_out(p_out[i]),
      .o_oe(p_oe[i]),
      .o_pu(p_pu[i]),
      .o_pd(p_pd[i]),
      .o_filt(p_filt[i]),
      .o_sink(p_sink[i]),
      .o_lvl(p_lvl[i])
    );
  end

  always_comb
  begin
    d = q;
    w = i_wdata[11:0];
    sel = cfg_sel(i_addr);
    clr = 12'h000;
    ev = 12'h000;
    for (int i = 0; i < pcgp_pkg::NPAD; i++)
    begin
      ev[i] = q.arm && (pin[i] ^ q.prev[i]) &&
        q.cfg[i][pcgp_pkg::CF_PSEL+:3] == pcgp_pkg::PSEL_PORT;
    end
    d.prev = pin;
    d.arm = 1'b1;
    if (i_wr)
    begin
      unique case (i_addr)
        pcgp_pkg::A_DATA: d.out = w;
        pcgp_pkg::A_MASK: d.mask = w;
        pcgp_pkg::A_MDATA: d.out = (q.out & ~q.mask) | (w & q.mask);
        pcgp_pkg::A_SET: d.out = q.out | w;
        pcgp_pkg::A_CLR: d.out = q.out & ~w;
        pcgp_pkg::A_DIR: d.dir = w;
        pcgp_pkg::A_DSET: d.dir = q.dir | w;
        pcgp_pkg::A_DCLR: d.dir = q.dir & ~w;
        pcgp_pkg::A_DTGL: d.dir = q.dir ^ w;
        pcgp_pkg::A_ICLR: clr = w;
        pcgp_pkg::A_IEN: d.ien = w;
        default:
        begin
          if (sel[4])
          begin
            d.cfg[sel[3:0]] = i_wdata[12:0];
          end
        end
      endcase
    end
    // A new edge wins over a clear in the same cycle
    d.ist = (q.ist & ~clr) | ev;
    d.rdata = 32'h0000_0000;
    if (i_rd)
    begin
      unique case (i_addr)
        pcgp_pkg::A_DATA: d.rdata = 32'(pin);
        pcgp_pkg::A_MASK: d.rdata = 32'(q.mask);
        pcgp_pkg::A_MDATA: d.rdata = 32'(pin & q.mask);
        pcgp_pkg::A_DIR: d.rdata = 32'(q.dir);
        pcgp_pkg::A_IST: d.rdata = 32'(q.ist);
        pcgp_pkg::A_IEN: d.rdata = 32'(q.ien);
        default:
        begin
          if (sel[4])
          begin
            d.rdata = 32'(q.cfg[sel[3:0]]);
          end
        end
      endcase
    end
    d.pad_o = p_out;
    d.pad_oe = p_oe;
    d.pu = p_pu;
    d.pd = p_pd;
    d.filt = p_filt;
    d.sink = p_sink;
    d.slvl = p_lvl;
    d.per_in = pin;
    d.irq = |(q.ist & q.ien);
    d.wake = q.ist[P_NWAKE-1:0] & q.ien[P_NWAKE-1:0];
    if (i_srst)
    begin
      d = '0;
      for (int i = 0; i < pcgp_pkg::NPAD; i++)
      begin
        d.cfg[i] = cfg_rst(i);
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    q <= d;
  end

  assign o_rdata = q.rdata;
  assign o_pad_out = q.pad_o;
  assign o_pad_oe = q.pad_oe;
  assign o_pull_up = q.pu;
  assign o_pull_dn = q.pd;
  assign o_bus_filt = q.filt;
  assign o_sink_en = q.sink;
  assign o_sink_lvl = q.slvl;
  assign o_per_in = q.per_in;
  assign o_port_irq = q.irq;
  assign o_wake = q.wake;

  property p_port_dir;
    @(posedge i_clk) disable iff (i_srst)
    q.cfg[0][2:0] == pcgp_pkg::PSEL_PORT |=>
      o_pad_oe[0] == $past(q.dir[0]) && o_pad_out[0] == $past(q.out[0]);
  endproperty
  a_port_dir: assert property (p_port_dir)
    else $error("port pad direction not taken from direction reg");

  property p_per_dir;
    @(posedge i_clk) disable iff (i_srst)
    q.cfg[0][2:0] != pcgp_pkg::PSEL_PORT |=>
      o_pad_oe[0] == $past(i_per_oe[0]);
  endproperty
  a_per_dir: assert property (p_per_dir)
    else $error("peripheral pad direction not from peripheral");

  property p_reset;
    @(posedge i_clk) disable iff (i_srst)
    $past(i_srst) |-> q.dir == 12'h000 && q.cfg[0] == pcgp_pkg::CFG_RST &&
      q.cfg[4] == pcgp_pkg::CFG_RST_BUS;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset configuration wrong");

  property p_rep;
    @(posedge i_clk) disable iff (i_srst)
    q.cfg[1][4:3] == 2'b11 && !i_dpd |=>
      o_pull_up[1] == $past(pin[1]) && o_pull_dn[1] == !$past(pin[1]);
  endproperty
  a_rep: assert property (p_rep)
    else $error("repeater pull does not follow pad level");

  property p_bus_od;
    @(posedge i_clk) disable iff (i_srst)
    q.cfg[4][2:0] != pcgp_pkg::PSEL_PORT |=> !o_pad_out[4];
  endproperty
  a_bus_od: assert property (p_bus_od)
    else $error("bus pad drives high");

  property p_full;
    @(posedge i_clk) disable iff (i_srst)
    i_wr && i_addr == pcgp_pkg::A_DATA |=> q.out == $past(i_wdata[11:0]);
  endproperty
  a_full: assert property (p_full)
    else $error("whole port write lost");

  property p_mask;
    @(posedge i_clk) disable iff (i_srst)
    i_wr && i_addr == pcgp_pkg::A_MDATA |=>
      ((q.out ^ $past(q.out)) & ~$past(q.mask)) == 12'h000;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked-off bit changed");

  property p_set;
    @(posedge i_clk) disable iff (i_srst)
    i_wr && i_addr == pcgp_pkg::A_SET |=>
      q.out == ($past(q.out) | $past(i_wdata[11:0]));
  endproperty
  a_set: assert property (p_set)
    else $error("set write wrong");

  property p_tgl;
    @(posedge i_clk) disable iff (i_srst)
    i_wr && i_addr == pcgp_pkg::A_DTGL |=>
      q.dir == ($past(q.dir) ^ $past(i_wdata[11:0]));
  endproperty
  a_tgl: assert property (p_tgl)
    else $error("direction toggle wrong");

  property p_rd;
    @(posedge i_clk) disable iff (i_srst)
    i_rd && i_addr == pcgp_pkg::A_DIR |=> o_rdata == 32'($past(q.dir));
  endproperty
  a_rd: assert property (p_rd)
    else $error("read data not one cycle later");

  property p_irq;
    @(posedge i_clk) disable iff (i_srst)
    ev[2] && q.ien[2] && !(i_wr && i_addr == pcgp_pkg::A_IEN) |=>
      ##1 o_port_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled edge did not raise port interrupt");

  property p_wake;
    @(posedge i_clk) disable iff (i_srst)
    q.ist[2] && q.ien[2] |=> o_wake[2];
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake line missing");

  property p_dpd;
    @(posedge i_clk) disable iff (i_srst)
    q.cfg[1][4:3] == 2'b11 && i_dpd |=> !o_pull_up[1] && !o_pull_dn[1];
  endproperty
  a_dpd: assert property (p_dpd)
    else $error("repeater pull held in deep power-down");

  c_irq: cover property (@(posedge i_clk) disable iff (i_srst)
    ev[0] ##2 o_port_irq);
  c_mask: cover property (@(posedge i_clk) disable iff (i_srst)
    i_wr && i_addr == pcgp_pkg::A_MDATA && q.mask != 12'h000);
  c_rep: cover property (@(posedge i_clk) disable iff (i_srst)
    q.cfg[1][4:3] == 2'b11 && o_pull_up[1]);
  c_dpd: cover property (@(posedge i_clk) disable iff (i_srst)
    i_dpd && q.cfg[1][4:3] == 2'b11);
endmodule

/* pkg/pcgp_pkg.sv */
package pcgp_pkg;
  localparam int NPAD = 12;
  localparam int NWAKE = 11;
  localparam int CFG_W = 13;
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_MASK = 8'h04;
  localparam logic [7:0] A_MDATA = 8'h08;
  localparam logic [7:0] A_SET = 8'h0c;
  localparam logic [7:0] A_CLR = 8'h10;
  localparam logic [7:0] A_DIR = 8'h14;
  localparam logic [7:0] A_DSET = 8'h18;
  localparam logic [7:0] A_DCLR = 8'h1c;
  localparam logic [7:0] A_DTGL = 8'h20;
  localparam logic [7:0] A_IST = 8'h24;
  localparam logic [7:0] A_ICLR = 8'h28;
  localparam logic [7:0] A_IEN = 8'h2c;
  localparam logic [7:0] A_CFG0 = 8'h40;
  localparam int CF_PSEL = 0;
  localparam int CF_MODE = 3;
  localparam int CF_BUSF = 5;
  localparam int CF_SINK = 6;
  localparam int CF_SINK_LO = 7;
  localparam int CF_SINK_HI = 10;
  localparam logic [2:0] PSEL_PORT = 3'h0;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_PD = 2'b01,
    MODE_PU = 2'b10,
    MODE_REP = 2'b11
  } pcgp_mode_t;
  localparam logic [12:0] CFG_RST = 13'h0000;
  localparam logic [12:0] CFG_RST_BUS = 13'h0021;
  localparam logic [12:0] CFG_RST_DBG = 13'h0011;
  localparam logic [11:0] BUS_MASK = 12'h030;
  localparam logic [11:0] DBG_MASK = 12'hc00;
  localparam logic [11:0] HD_MASK = 12'hc88;
endpackage
